// ---- cpu_core_model.sv ----
// Behavioural CPU core that issues store and load program memory instructions
`timescale 1ns/1ns
module cpu_core_model (
	// Clock
	input wire logic pclk,
	// Instruction side
	output logic store_instr,
	output logic load_instr,
	output logic [15:0] program_pointer,
	output logic [15:0] data_register_pair,
	input wire logic [7:0] load_data,
	input wire logic load_valid
);
	initial
	begin
		store_instr = 1'b0;
		load_instr = 1'b0;
		program_pointer = 16'h0000;
		data_register_pair = 16'h0000;
	end
	// Data pair is inverted once sampled, so a late capture shows up
	task store(input logic [15:0] ptr, input logic [15:0] dat);
		store_instr <= 1'b1;
		program_pointer <= ptr;
		data_register_pair <= dat;
		@(posedge pclk);
		store_instr <= 1'b0;
		data_register_pair <= ~dat;
		@(posedge pclk);
	endtask
	// A missing answer leaves the result unknown, which no compare accepts
	task load(input logic [15:0] ptr, output logic [7:0] got);
		int n;
		got = 8'hxx;
		load_instr <= 1'b1;
		program_pointer <= ptr;
		@(posedge pclk);
		load_instr <= 1'b0;
		for (n = 0; n < 4; n++)
		begin
			@(posedge pclk);
			if (load_valid === 1'b1)
			begin
				got = load_data;
				break;
			end
		end
	endtask
endmodule

// ---- self_program_flash_control.sv ----
// Self-programming flash sequencer with APB control register and page buffer
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "self_program_flash_control_params.svh"

// Summary of operation
// - Pointer high bits page, low bits word
// - Byte load picks byte by pointer lsb
// - Bit 7 always reads zero
// - Busy flag bit 6 always reads zero
// - Signature load in three; store ends it
// - Clear-buffer command empties page buffer
// - Fuse/lock load in three, two lsbs select
// - Page write stores buffer to pointer page
// - Write bit clears on done or timeout
// - Page erase of pointer page, self-clears
// - CPU stalled through erase and write
// - Enable alone loads data pair to buffer
// - Enable clears on store/timeout; busy during ops
// - Only six command patterns take effect
// - EEPROM write blocks flash ops, fuse reads
// - Pointer one returns two lock bits
// - Pointer zero returns low fuse byte
// - Pointer three returns high fuse byte
// - Pointer two returns extended fuse bit
// - Programmed bits read zero, unprogrammed one
// - Fuse read clears after use or timeout
// - Buffer cleared after page write, reset
// - Erase and write last programming time
module self_program_flash_control
	import spf_pkg::*;
#(
	parameter int PAGE_WORDS = 64,
	parameter int ADDR_W = 8,
	parameter int OP_CYCLES = (`PROG_TIME_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// CPU core instruction side
	input wire logic store_instr,
	input wire logic load_instr,
	input wire logic [15:0] program_pointer,
	input wire logic [15:0] data_register_pair,
	output logic [7:0] load_data,
	output logic load_valid,
	output logic cpu_stall,
	// Nonvolatile sources; on the lock and fuse inputs a set bit means programmed
	input wire logic [15:0] flash_rd_data,
	input wire logic [7:0] signature_row_byte,
	input wire logic [1:0] lock_programmed,
	input wire logic [7:0] fuse_low_programmed,
	input wire logic [7:0] fuse_high_programmed,
	input wire logic fuse_ext_programmed,
	input wire logic eeprom_write_busy,
	// Flash array side
	output logic flash_erase,
	output logic flash_wr_strobe,
	output logic [15:0] flash_page,
	output logic [$clog2(PAGE_WORDS)-1:0] flash_wr_word,
	output logic [15:0] flash_wr_data
);
	localparam int WORD_BITS = $clog2(PAGE_WORDS);
	localparam int OPC_W = $clog2(OP_CYCLES + 1);

	seq_state_t st_r;
	cmd_t cmd_r;
	cmd_t dec;
	logic [2:0] win_r;
	logic [OPC_W-1:0] opcnt_r;
	logic [15:0] buf_r [PAGE_WORDS];
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [7:0] load_data_r;
	logic load_valid_r;
	logic cpu_stall_r;
	logic flash_erase_r;
	logic flash_wr_strobe_r;
	logic [15:0] flash_page_r;
	logic [WORD_BITS-1:0] flash_wr_word_r;
	logic [15:0] flash_wr_data_r;
	logic eeb_d_r;
	logic [7:0] csr_rd;
	logic [7:0] fuse_byte;
	logic [7:0] load_byte;
	logic [WORD_BITS-1:0] word_idx;
	logic [WORD_BITS-1:0] stream_idx;
	logic [15:0] page_idx;
	logic op_busy;
	logic bus_access;
	logic wr_csr;
	logic csr_wr_ok;
	logic clear_buf;
	logic load_win;
	logic read_mode;
	logic last_op_cycle;

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign load_data = load_data_r;
	assign load_valid = load_valid_r;
	assign cpu_stall = cpu_stall_r;
	assign flash_erase = flash_erase_r;
	assign flash_wr_strobe = flash_wr_strobe_r;
	assign flash_page = flash_page_r;
	assign flash_wr_word = flash_wr_word_r;
	assign flash_wr_data = flash_wr_data_r;

	assign word_idx = program_pointer[WORD_BITS:1];
	assign page_idx = program_pointer >> (WORD_BITS + 1);
	assign stream_idx = opcnt_r[WORD_BITS-1:0];
	assign op_busy = (st_r == ST_ERASE) || (st_r == ST_WRITE);
	assign last_op_cycle = opcnt_r == OPC_W'(OP_CYCLES - 1);
	// Loads are served on the first three cycles of the four-cycle window
	assign load_win = (st_r == ST_ARMED) && (win_r >= `LOAD_WINDOW_MIN);
	assign read_mode = (cmd_r == CMD_SIG) || (cmd_r == CMD_FUSE);

	// The bus belongs to the halted CPU, so it is held off during an operation
	assign bus_access = psel && penable && !pready_r && !op_busy;
	assign wr_csr = psel && penable && pready_r && pwrite && (paddr == ADDR_W'(`CSR_OFFSET));
	assign csr_wr_ok = wr_csr && !eeprom_write_busy && (st_r == ST_IDLE);

	always_comb
	begin
		case (pwdata[5:0])
			`PAT_SIG: dec = CMD_SIG;
			`PAT_CLEAR_PAGE_BUFFER: dec = CMD_CLEAR_PAGE_BUFFER;
			`PAT_FUSE: dec = CMD_FUSE;
			`PAT_WRITE: dec = CMD_WRITE;
			`PAT_ERASE: dec = CMD_ERASE;
			`PAT_LOAD: dec = CMD_LOAD;
			default: dec = CMD_NONE;
		endcase
	end

	always_comb
	begin
		csr_rd = `CSR_RESET;
		csr_rd[`CSR_EN_BIT] = st_r != ST_IDLE;
		csr_rd[`CSR_ERASE_BIT] = cmd_r == CMD_ERASE;
		csr_rd[`CSR_WRITE_BIT] = cmd_r == CMD_WRITE;
		csr_rd[`CSR_FUSE_BIT] = cmd_r == CMD_FUSE;
		csr_rd[`CSR_CLEAR_PAGE_BUFFER_BIT] = cmd_r == CMD_CLEAR_PAGE_BUFFER;
		csr_rd[`CSR_SIG_BIT] = cmd_r == CMD_SIG;
	end

	// Stored flags mean programmed; software sees them inverted
	always_comb
	begin
		case (program_pointer[1:0])
			`SEL_FUSE_LOW: fuse_byte = ~fuse_low_programmed;
			`SEL_LOCK: fuse_byte = {6'h3f, ~lock_programmed};
			`SEL_FUSE_EXT: fuse_byte = {7'h7f, ~fuse_ext_programmed};
			`SEL_FUSE_HIGH: fuse_byte = ~fuse_high_programmed;
			default: fuse_byte = 8'hff;
		endcase
	end

	always_comb
	begin
		load_byte = program_pointer[0] ? flash_rd_data[15:8] : flash_rd_data[7:0];
		if (load_win && (cmd_r == CMD_SIG))
			load_byte = signature_row_byte;
		else if (load_win && (cmd_r == CMD_FUSE) && !eeprom_write_busy)
			load_byte = fuse_byte;
	end

	// APB slave: one wait state outside erase and write, pslverr on any address but the control register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end
		else
		begin
			pready_r <= bus_access;
			pslverr_r <= bus_access && (paddr != ADDR_W'(`CSR_OFFSET));
			if (bus_access && !pwrite && (paddr == ADDR_W'(`CSR_OFFSET)))
				prdata_r <= {24'h00_0000, csr_rd};
			else
				prdata_r <= 32'h0000_0000;
		end
	end

	// Command sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r <= ST_IDLE;
			cmd_r <= CMD_NONE;
			win_r <= 3'h0;
			opcnt_r <= '0;
			cpu_stall_r <= 1'b0;
		end
		else
		begin
			case (st_r)
				ST_IDLE:
				begin
					if (csr_wr_ok && (dec != CMD_NONE))
					begin
						cmd_r <= dec;
						win_r <= `STORE_WINDOW;
						st_r <= ST_ARMED;
					end
				end
				ST_ARMED:
				begin
					win_r <= win_r - 3'h1;
					if (store_instr && (cmd_r == CMD_ERASE))
					begin
						st_r <= ST_ERASE;
						opcnt_r <= '0;
						cpu_stall_r <= 1'b1;
					end
					else if (store_instr && (cmd_r == CMD_WRITE))
					begin
						st_r <= ST_WRITE;
						opcnt_r <= '0;
						cpu_stall_r <= 1'b1;
					end
					else if (store_instr)
					begin
						// Buffer load ends here; signature, fuse and clear modes also end on the store
						st_r <= ST_IDLE;
						cmd_r <= CMD_NONE;
					end
					else if (load_instr && load_win && (cmd_r == CMD_SIG))
					begin
						st_r <= ST_IDLE;
						cmd_r <= CMD_NONE;
					end
					else if (load_instr && load_win && (cmd_r == CMD_FUSE) && !eeprom_write_busy)
					begin
						st_r <= ST_IDLE;
						cmd_r <= CMD_NONE;
					end
					// Read modes give up after the three load cycles; stores get four
					else if ((win_r == 3'h1) || (read_mode && (win_r == `LOAD_WINDOW_MIN)))
					begin
						st_r <= ST_IDLE;
						cmd_r <= CMD_NONE;
					end
				end
				ST_ERASE, ST_WRITE:
				begin
					// Minimum programming time, so the array is never cut short
					opcnt_r <= opcnt_r + OPC_W'(1);
					if (last_op_cycle)
					begin
						st_r <= ST_IDLE;
						cmd_r <= CMD_NONE;
						cpu_stall_r <= 1'b0;
					end
				end
				default:
				begin
					st_r <= ST_IDLE;
					cmd_r <= CMD_NONE;
				end
			endcase
		end
	end

	// CPU load answers one cycle after the instruction
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			load_valid_r <= 1'b0;
			load_data_r <= 8'h00;
		end
		else
		begin
			load_valid_r <= load_instr;
			if (load_instr)
				load_data_r <= load_byte;
		end
	end

	// An EEPROM write starting mid-load would corrupt the buffer, so it is dropped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			eeb_d_r <= 1'b0;
		else
			eeb_d_r <= eeprom_write_busy;
	end

	assign clear_buf = (csr_wr_ok && (dec == CMD_CLEAR_PAGE_BUFFER))
		|| ((st_r == ST_WRITE) && last_op_cycle)
		|| (eeprom_write_busy && !eeb_d_r);

	// Temporary page buffer, erased state on reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < PAGE_WORDS; i++)
				buf_r[i] <= `ERASED_WORD;
		end
		else if (clear_buf)
		begin
			for (int i = 0; i < PAGE_WORDS; i++)
				buf_r[i] <= `ERASED_WORD;
		end
		else if ((st_r == ST_ARMED) && (cmd_r == CMD_LOAD) && store_instr)
			buf_r[word_idx] <= data_register_pair;
	end

	// Array side: erase pulse, then buffer words streamed one per cycle on write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flash_erase_r <= 1'b0;
			flash_wr_strobe_r <= 1'b0;
			flash_page_r <= 16'h0000;
			flash_wr_word_r <= '0;
			flash_wr_data_r <= 16'h0000;
		end
		else
		begin
			flash_erase_r <= (st_r == ST_ARMED) && (cmd_r == CMD_ERASE) && store_instr;
			if ((st_r == ST_ARMED) && store_instr)
				flash_page_r <= page_idx;
			flash_wr_strobe_r <= (st_r == ST_WRITE) && (opcnt_r < OPC_W'(PAGE_WORDS));
			flash_wr_word_r <= stream_idx;
			flash_wr_data_r <= buf_r[stream_idx];
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_reserved_zero: assert property (
		$rose(pready_r) && !pwrite |-> prdata_r[7:6] == 2'b00)
		else $error("reserved control bits read nonzero");
	a_window_expiry: assert property (
		(st_r == ST_IDLE ##1 st_r == ST_ARMED) ##0 (!store_instr && !load_instr)[*4]
		|=> st_r == ST_IDLE)
		else $error("armed window did not expire after four cycles");
	a_read_expiry: assert property (
		(st_r == ST_IDLE ##1 st_r == ST_ARMED && read_mode) ##0 (!load_instr)[*3]
		|=> st_r == ST_IDLE)
		else $error("read window did not expire after three cycles");
	a_stall_op: assert property (
		cpu_stall_r == op_busy)
		else $error("cpu stall does not match operation");
	a_op_busy_bits: assert property (
		st_r == ST_ERASE |-> csr_rd[`CSR_EN_BIT] && csr_rd[`CSR_ERASE_BIT])
		else $error("enable or erase bit low during erase");
	a_erase_page: assert property (
		st_r == ST_ARMED && cmd_r == CMD_ERASE && store_instr
		|=> flash_erase_r && flash_page_r == $past(page_idx) ##1 st_r == ST_ERASE)
		else $error("erase not started on pointer page");
	a_load_word: assert property (
		st_r == ST_ARMED && cmd_r == CMD_LOAD && store_instr && !clear_buf
		|=> buf_r[$past(word_idx)] == $past(data_register_pair) && st_r == ST_IDLE)
		else $error("buffer word not loaded");
	a_clear_page_buffer_clear: assert property (
		csr_wr_ok && dec == CMD_CLEAR_PAGE_BUFFER |=> buf_r[0] == `ERASED_WORD && st_r == ST_ARMED)
		else $error("buffer not cleared");
	a_lock_read: assert property (
		load_instr && load_win && cmd_r == CMD_FUSE && !eeprom_write_busy
		&& program_pointer[1:0] == `SEL_LOCK
		|=> load_data_r == {6'h3f, ~$past(lock_programmed)} && st_r == ST_IDLE)
		else $error("lock bits read wrong");
	a_eeprom_block: assert property (
		st_r == ST_IDLE && wr_csr && eeprom_write_busy |=> st_r == ST_IDLE)
		else $error("command taken during eeprom write");
	a_bad_pattern: assert property (
		st_r == ST_IDLE && wr_csr && dec == CMD_NONE |=> st_r == ST_IDLE && cmd_r == CMD_NONE)
		else $error("illegal pattern had effect");
	a_write_end: assert property (
		st_r == ST_WRITE && last_op_cycle |=> st_r == ST_IDLE && buf_r[0] == `ERASED_WORD)
		else $error("page write end not handled");
	a_byte_select: assert property (
		load_instr && st_r == ST_IDLE
		|=> load_data_r == ($past(program_pointer[0]) ? $past(flash_rd_data[15:8])
			: $past(flash_rd_data[7:0])))
		else $error("wrong byte of flash word");
endmodule

// ---- self_program_flash_control_params.svh ----
// Constants for the self-programming flash control block
`ifndef SELF_PROGRAM_FLASH_CONTROL_PARAMS_SVH
`define SELF_PROGRAM_FLASH_CONTROL_PARAMS_SVH
`define CSR_OFFSET 8'h00
`define CSR_RESET 8'h00
`define CSR_EN_BIT 0
`define CSR_ERASE_BIT 1
`define CSR_WRITE_BIT 2
`define CSR_FUSE_BIT 3
`define CSR_CLEAR_PAGE_BUFFER_BIT 4
`define CSR_SIG_BIT 5
`define PAT_SIG 6'h21
`define PAT_CLEAR_PAGE_BUFFER 6'h11
`define PAT_FUSE 6'h09
`define PAT_WRITE 6'h05
`define PAT_ERASE 6'h03
`define PAT_LOAD 6'h01
`define STORE_WINDOW 3'h4
`define LOAD_WINDOW_MIN 3'h2
`define PROG_TIME_MIN_NS 3700000
`define PROG_TIME_MAX_NS 4500000
`define CLK_PERIOD_NS 40
`define ERASED_WORD 16'hffff
`define SEL_FUSE_LOW 2'h0
`define SEL_LOCK 2'h1
`define SEL_FUSE_EXT 2'h2
`define SEL_FUSE_HIGH 2'h3
`endif

// ---- self_program_flash_control_tb.sv ----
// Self-checking bench for the self-programming flash control block
`timescale 1ns/1ns
module self_program_flash_control_tb;
	localparam int OPC = 16;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0] paddr, load_data, got, fuse_low_programmed, fuse_high_programmed;
	logic [31:0] pwdata, prdata, rdat;
	logic store_instr, load_instr, load_valid, cpu_stall, fuse_ext_programmed;
	logic [15:0] program_pointer, data_register_pair, flash_rd_data, flash_page;
	logic [15:0] flash_wr_data, page_seen;
	logic [7:0] signature_row_byte;
	logic [1:0] lock_programmed, flash_wr_word;
	logic eeprom_write_busy, flash_erase, flash_wr_strobe;
	logic [15:0] wr_seen [4];
	logic [7:0] fx [4] = '{8'h69, 8'hfd, 8'hfe, 8'hf0};
	logic [7:0] pats [5] = '{8'h01, 8'h05, 8'h03, 8'h09, 8'h21};
	logic [7:0] bad [4] = '{8'h07, 8'h31, 8'h02, 8'h0b};
	int fails = 0;
	int checks_done = 0;
	int wr_cnt = 0, stall_cnt = 0, erase_cnt = 0;
	int wr_base, stall_base, erase_base;

	self_program_flash_control #(.PAGE_WORDS(4), .OP_CYCLES(OPC)) self_program_flash_control_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.store_instr(store_instr), .load_instr(load_instr), .program_pointer(program_pointer),
		.data_register_pair(data_register_pair), .load_data(load_data),
		.load_valid(load_valid), .cpu_stall(cpu_stall), .flash_rd_data(flash_rd_data),
		.signature_row_byte(signature_row_byte), .lock_programmed(lock_programmed),
		.fuse_low_programmed(fuse_low_programmed), .fuse_high_programmed(fuse_high_programmed),
		.fuse_ext_programmed(fuse_ext_programmed), .eeprom_write_busy(eeprom_write_busy),
		.flash_erase(flash_erase), .flash_wr_strobe(flash_wr_strobe), .flash_page(flash_page),
		.flash_wr_word(flash_wr_word), .flash_wr_data(flash_wr_data));
	cpu_core_model cpu_core_model_inst (.pclk(pclk), .store_instr(store_instr),
		.load_instr(load_instr), .program_pointer(program_pointer),
		.data_register_pair(data_register_pair), .load_data(load_data), .load_valid(load_valid));

	always #20 pclk = ~pclk;
	always @(posedge pclk)
	begin
		if (flash_wr_strobe === 1'b1)
		begin
			wr_seen[flash_wr_word] <= flash_wr_data;
			wr_cnt <= wr_cnt + 1;
			page_seen <= flash_page;
		end
		if (cpu_stall === 1'b1)
			stall_cnt <= stall_cnt + 1;
		if (flash_erase === 1'b1)
		begin
			erase_cnt <= erase_cnt + 1;
			page_seen <= flash_page;
		end
	end

	task tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
		checks_done++;
		if (seen !== exp)
		begin
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
			fails++;
		end
	endtask
	// Ends one idle edge after the transfer so back-to-back calls never collide
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 200);
		if (pready !== 1'b1)
		begin
			fails++;
			tally_and_finish();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rdc(input string nm, input logic [31:0] exp);
		apb(1'b0, 8'h00, 8'h00);
		chk(nm, exp, rdat);
	endtask
	task page_op(input logic [7:0] cmd, input logic [15:0] ptr);
		// Counters belong to the monitor; each operation is measured from a snapshot
		wr_base = wr_cnt;
		stall_base = stall_cnt;
		erase_base = erase_cnt;
		apb(1'b1, 8'h00, cmd);
		cpu_core_model_inst.store(ptr, 16'hdead);
		rdc("ctrl after op", 32'h0);
		chk("stall cycles", OPC, stall_cnt - stall_base);
		chk("page", {3'h0, ptr[15:3]}, page_seen);
	endtask
	task load_words();
		for (int k = 0; k < 4; k++)
		begin
			apb(1'b1, 8'h00, 8'h01);
			cpu_core_model_inst.store({13'h0005, k[1:0], 1'b1}, 16'h1000 + 16'(k));
		end
	endtask
	task chk_words(input bit loaded);
		chk("word count", 4, wr_cnt - wr_base);
		for (int k = 0; k < 4; k++)
			chk("page word", loaded ? 16'h1000 + k : 16'hffff, wr_seen[k]);
	endtask

	initial
	begin
		repeat (20000) @(posedge pclk);
		fails++;
		tally_and_finish();
	end
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		flash_rd_data = 16'ha55a;
		signature_row_byte = 8'h3c;
		lock_programmed = 2'h2;
		fuse_low_programmed = 8'h96;
		fuse_high_programmed = 8'h0f;
		fuse_ext_programmed = 1'b1;
		eeprom_write_busy = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc("ctrl reset", 32'h0);
		apb(1'b0, 8'h04, 8'h00);
		chk("unmapped err", 32'h1, rerr);
		chk("unmapped data", 32'h0, rdat);
		apb(1'b1, 8'h00, 8'hc1);
		rdc("ctrl armed", 32'h01);
		apb(1'b1, 8'h00, 8'h21);
		@(posedge pclk);
		rdc("ctrl sig window", 32'h0);
		apb(1'b1, 8'h00, 8'h09);
		@(posedge pclk);
		rdc("ctrl fuse window", 32'h0);
		apb(1'b1, 8'h00, 8'h01);
		@(posedge pclk);
		rdc("ctrl store window", 32'h01);
		foreach (pats[i])
		begin
			apb(1'b1, 8'h00, pats[i]);
			repeat (5) @(posedge pclk);
			rdc("ctrl timeout", 32'h0);
		end
		foreach (bad[i])
		begin
			apb(1'b1, 8'h00, bad[i]);
			rdc("ctrl bad pattern", 32'h0);
		end
		$display("test control register done");
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, 8'h00, 8'h09);
			cpu_core_model_inst.load({14'h0, i[1:0]}, got);
			chk("fuse lock byte", fx[i], got);
			rdc("ctrl after fuse", 32'h0);
		end
		apb(1'b1, 8'h00, 8'h21);
		cpu_core_model_inst.load(16'h0004, got);
		chk("signature", 8'h3c, got);
		cpu_core_model_inst.load(16'h0001, got);
		chk("load high byte", 8'ha5, got);
		cpu_core_model_inst.load(16'h0000, got);
		chk("load low byte", 8'h5a, got);
		$display("test loads done");
		load_words();
		page_op(8'h05, 16'h0038);
		chk_words(1'b1);
		page_op(8'h05, 16'h0010);
		chk_words(1'b0);
		load_words();
		apb(1'b1, 8'h00, 8'h11);
		repeat (5) @(posedge pclk);
		page_op(8'h05, 16'h0018);
		chk_words(1'b0);
		load_words();
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		page_op(8'h05, 16'h0020);
		chk_words(1'b0);
		page_op(8'h03, 16'h0048);
		chk("erase pulses", 32'h1, erase_cnt - erase_base);
		chk("erase writes", 32'h0, wr_cnt - wr_base);
		$display("test page operations done");
		apb(1'b1, 8'h00, 8'h09);
		eeprom_write_busy <= 1'b1;
		cpu_core_model_inst.load(16'h0000, got);
		chk("fuse read blocked", 8'h5a, got);
		apb(1'b1, 8'h00, 8'h09);
		rdc("ctrl eeprom busy", 32'h0);
		eeprom_write_busy <= 1'b0;
		$display("test eeprom block done");
		tally_and_finish();
	end
endmodule

// ---- spf_pkg.sv ----
// Types for the self-programming flash control block
package spf_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_ERASE, ST_WRITE} seq_state_t;
	typedef enum logic [2:0] {CMD_NONE, CMD_SIG, CMD_CLEAR_PAGE_BUFFER, CMD_FUSE, CMD_WRITE, CMD_ERASE,
		CMD_LOAD} cmd_t;
endpackage

// ---- spf_pkg_order_note_placeholder_removed.sv ----
// Intentionally empty compile unit
`timescale 1ns/1ns
